/* scp_host.sv */
////////////////////////////////////////
// Purpose: Serial master model driving the port
// Assumes: Serial clock idles low between frames
// Notes:   A released data line shows the inverse bit
////////////////////////////////////////
`timescale 1ns/10ps
module scp_host (
  output logic      sck,
  output logic      cs_n,
  output wire logic sdl,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic sdo,
  input  wire logic four_wire
);
  logic       hd;
  logic       hen;
  logic [7:0] rd_q;
  int         oe_n;
  // Resolved level of the shared data line
  assign sdl = sdio_oe ? sdio_out : (hen ? hd : ~hd);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hd = 1'b0;
    hen = 1'b0;
    rd_q = 8'h00;
    oe_n = 0;
  end
  // One frame of nbits from the top of bits
  task automatic frame(input logic [23:0] bits, input int nbits);
    cs_n = 1'b0;
    oe_n = 0;
    for (int i = 0; i < nbits; i++) begin
      hen = !(bits[23] && i >= 16);
      if (hen) hd = bits[23-i];
      #62.5 sck = 1'b1;
      if (i >= 16) rd_q = {rd_q[6:0], four_wire ? sdo : sdl};
      if (sdio_oe === 1'b1) oe_n++;
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    hen = 1'b0;
  endtask
endmodule // scp_host

/* scp_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants and carrier types of the serial configuration port
// Assumes: Frame is R/W bit, address, data, most significant bit first
// Notes:   Frame layout and store depth are fixed here
//////////////////////////////////////////////////////////////////////////////
package scp_pkg;

  // Frame field widths
  localparam int unsigned ADDR_W    = 15;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned FRAME_W   = 1 + ADDR_W + DATA_W;
  localparam int unsigned CNT_W     = 5;

  // Bit counts inside a frame
  localparam logic [CNT_W-1:0] HDR_CNT   = 5'h10;  // R/W plus address bits
  localparam logic [CNT_W-1:0] LAST_CNT  = 5'h17;  // Count before the final bit
  localparam logic [CNT_W-1:0] MAX_CNT   = 5'h1f;  // Counter saturation

  // Register store
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned DEPTH     = 32;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;

  // Layout of a received frame
  typedef struct packed {
    logic              rw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scp_frame_t;

  // Committed register write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scp_wr_t;

endpackage

/* scp_port.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Serial configuration port, slave side of a 3/4-wire serial link
// Assumes: Serial clock idles while frame select is high
// Notes:   Frame select high clears the link-side counter and drivers
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module scp_port (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       sck,
  input  wire logic                       cs_n,
  input  wire logic                       serial_data_in,
  output logic                            sdio_out,
  output logic                            sdio_oe,
  output logic                            sdo,
  input  wire logic                       four_wire,
  output logic                            wr_valid,
  output scp_pkg::scp_wr_t                wr
);

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: shift in on rising edges

  logic [scp_pkg::FRAME_W-1:0] shift_q;
  logic [scp_pkg::CNT_W-1:0]   cnt_q;
  logic                        rw_q;
  logic                        frame_ok_q;
  logic                        fw_s1_q;
  logic                        fw_s2_q;

  scp_pkg::scp_frame_t frame_w;
  wire cnt_sat_w = (cnt_q == scp_pkg::MAX_CNT);
  assign frame_w = scp_pkg::scp_frame_t'(shift_q);

  // Bit counter, cleared by frame select high
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= '0;
    end else if (!cnt_sat_w) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Shift register keeps its content after the frame for the commit
  always_ff @(posedge sck) begin
    if (!cs_n) begin
      shift_q <= {shift_q[scp_pkg::FRAME_W-2:0], serial_data_in};
    end
  end

  // R/W bit is the first bit, frame is complete on the final edge
  always_ff @(posedge sck) begin
    if (!cs_n && cnt_q == '0) begin
      rw_q <= serial_data_in;
    end
    if (!cs_n) begin
      frame_ok_q <= (cnt_q == scp_pkg::LAST_CNT);
    end
  end

  // Mode pin synchroniser on the link clock
  always_ff @(posedge sck) begin
    fw_s1_q <= four_wire;
    fw_s2_q <= fw_s1_q;
  end

  // Checks on the shift side
  a_shift_in_bit: assert property (@(posedge sck) disable iff (cs_n)
    1'b1 |=> shift_q[0] == $past(serial_data_in))
    else $error("Data bit not shifted in on rising edge");

  a_rw_first_bit: assert property (@(posedge sck) disable iff (cs_n)
    (cnt_q == '0) |=> (rw_q == $past(serial_data_in)) && (cnt_q == 5'h01))
    else $error("R/W bit not taken from first bit");

  a_frame_len_ok: assert property (@(posedge sck) disable iff (cs_n)
    1'b1 |=> frame_ok_q == ($past(cnt_q) == scp_pkg::LAST_CNT))
    else $error("Frame length flag does not match the bit count");

  a_rw_hold: assert property (@(posedge sck) disable iff (cs_n)
    (cnt_q != '0) |=> $stable(rw_q))
    else $error("R/W bit changed after the first bit");

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: read-back launched on falling edges

  logic [scp_pkg::DATA_W-1:0] rd_sh_q;
  logic [scp_pkg::DATA_W-1:0] rd_data_w;

  wire load_w   = rw_q && (cnt_q == scp_pkg::HDR_CNT);
  wire [scp_pkg::IDX_W-1:0] rd_idx_w = shift_q[scp_pkg::IDX_W-1:0];

  // Drivers released whenever frame select is high
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      sdio_oe  <= 1'b0;
      sdio_out <= 1'b0;
      sdo      <= 1'b0;
      rd_sh_q  <= '0;
    end else if (load_w) begin
      rd_sh_q  <= {rd_data_w[scp_pkg::DATA_W-2:0], 1'b0};
      sdio_oe  <= !fw_s2_q;
      sdio_out <= rd_data_w[scp_pkg::DATA_W-1];
      sdo      <= fw_s2_q & rd_data_w[scp_pkg::DATA_W-1];
    end else begin
      rd_sh_q  <= {rd_sh_q[scp_pkg::DATA_W-2:0], 1'b0};
      sdio_out <= rd_sh_q[scp_pkg::DATA_W-1];
      sdo      <= fw_s2_q & rd_sh_q[scp_pkg::DATA_W-1];
    end
  end

  // Checks on the read-back side
  a_read_first_bit: assert property (@(negedge sck) disable iff (cs_n)
    load_w |=> ((fw_s2_q ? sdo : sdio_out) == $past(rd_data_w[scp_pkg::DATA_W-1])))
    else $error("First read-back bit not launched after falling edge");

  a_read_oe_mode: assert property (@(negedge sck) disable iff (cs_n)
    sdio_oe |-> rw_q && !fw_s2_q)
    else $error("Data line driven outside a 3-wire read");

  a_four_wire_same: assert property (@(negedge sck) disable iff (cs_n)
    fw_s2_q && $stable(fw_s2_q) |-> (sdo == sdio_out) && !sdio_oe)
    else $error("4-wire output differs from read-back bit");

  a_read_next_bit: assert property (@(negedge sck) disable iff (cs_n)
    !load_w |=> sdio_out == $past(rd_sh_q[scp_pkg::DATA_W-1]))
    else $error("Read-back bit not shifted out after falling edge");

  a_oe_on_load: assert property (@(negedge sck) disable iff (cs_n)
    load_w && !fw_s2_q |=> sdio_oe)
    else $error("Data line not driven after the address of a 3-wire read");

  a_oe_during_read: assert property (@(negedge sck) disable iff (cs_n)
    rw_q && !fw_s2_q && $stable(fw_s2_q) && (cnt_q > scp_pkg::HDR_CNT) |-> sdio_oe)
    else $error("Data line released inside a 3-wire read");

  a_sdo_quiet: assert property (@(negedge sck) disable iff (cs_n)
    !fw_s2_q && $stable(fw_s2_q) |-> !sdo)
    else $error("Separate read-back output active in 3-wire mode");

  a_no_drive_write: assert property (@(negedge sck) disable iff (cs_n)
    !rw_q |-> !sdio_oe && !sdo)
    else $error("Read-back outputs active in a write frame");

  //////////////////////////////////////////////////////////////////////////////
  // System domain: commit on frame select rise

  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;

  // Crossing: shift register and frame flag move only on serial clock
  // rises with frame select low, so they are quasi-static here
  // Commit samples them on the third system clock edge after frame select has risen
  // Hazard: a host that restarts a frame inside that window breaks this,
  // hence the minimum high time of frame select between frames
  // No other word passes from the link clock to the system clock
  wire cs_rise_w = cs_s2_q && !cs_s3_q;
  wire commit_w  = cs_rise_w && frame_ok_q && !frame_w.rw;

  // Frame select synchroniser and edge history
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // Write notice, shift register is stable while frame select is high
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr       <= '0;
    end else begin
      wr_valid <= commit_w;
      if (commit_w) begin
        wr <= '{addr: frame_w.addr, data: frame_w.data};
      end
    end
  end

  // Store entries change only at a commit, shortly after frame select rises
  // Link side reads them combinationally once the address is complete,
  // long after any pending commit has landed
  // Store written on commit, read from the link domain
  scp_store u_store (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr_en   (commit_w),
    .wr_idx  (frame_w.addr[scp_pkg::IDX_W-1:0]),
    .wr_data (frame_w.data),
    .rd_idx  (rd_idx_w),
    .rd_data (rd_data_w)
  );

  // Checks on the commit side
  a_commit_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit_w |=> wr_valid && (wr.addr == $past(frame_w.addr)) && (wr.data == $past(frame_w.data)))
    else $error("Write frame not committed on frame select rise");

  a_no_read_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    cs_rise_w && frame_w.rw |=> !wr_valid)
    else $error("Read frame caused a register write");

  a_commit_once: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_valid |-> !$past(wr_valid) && $past(cs_s2_q) && !$past(cs_s3_q))
    else $error("Write notice not tied to a single frame select rise");

  a_valid_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_valid |=> !wr_valid)
    else $error("Write notice longer than one cycle");

  a_short_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
    cs_rise_w && !frame_ok_q |=> !wr_valid)
    else $error("Frame of wrong length caused a register write");

  a_wr_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    !commit_w |=> $stable(wr))
    else $error("Write word changed without a commit");

endmodule // scp_port

/* scp_store.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Register store written by committed frames
// Assumes: Read address is stable whenever its data is used
// Notes:   Low address bits index the store
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module scp_store (
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire logic                        wr_en,
  input  wire logic [scp_pkg::IDX_W-1:0]   wr_idx,
  input  wire logic [scp_pkg::DATA_W-1:0]  wr_data,
  input  wire logic [scp_pkg::IDX_W-1:0]   rd_idx,
  output wire logic [scp_pkg::DATA_W-1:0]  rd_data
);

  logic [scp_pkg::DATA_W-1:0] mem_q [scp_pkg::DEPTH];

  // One entry per generate step, each with its own reset
  for (genvar i = 0; i < scp_pkg::DEPTH; i++) begin : g_ent
    wire sel_w = wr_en && (wr_idx == (scp_pkg::IDX_W)'(i));
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        mem_q[i] <= scp_pkg::REG_RST;
      end else if (sel_w) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  // Read port
  assign rd_data = mem_q[rd_idx];

endmodule // scp_store

/* tb_top.sv */
////////////////////////////////////////
// Purpose: Self-checking bench of the port
// Assumes: Store index is the low address bits
// Notes:   Gap after each frame is 8 system cycles
////////////////////////////////////////
`timescale 1ns/10ps
module tb_top;
  logic             clk_sys = 1'b0;
  logic             nrst = 1'b0;
  logic             four_wire = 1'b0;
  wire logic        sck, cs_n, sdl, sdio_out, sdio_oe, sdo, wr_valid;
  scp_pkg::scp_wr_t wr, got, last;
  int               num_errors = 0, cmp_count = 0, nv, seed = 32'h598e;
  logic [7:0]       mem [32];
  logic [14:0]      a;
  logic [7:0]       d;
  always #10 clk_sys = ~clk_sys;
  scp_port u_dut (.clk_sys(clk_sys), .nrst(nrst), .sck(sck), .cs_n(cs_n), .serial_data_in(sdl),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo(sdo), .four_wire(four_wire), .wr_valid(wr_valid), .wr(wr));
  scp_host u_host (.sck(sck), .cs_n(cs_n), .sdl(sdl), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sdo(sdo), .four_wire(four_wire));
  ////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Count commit pulses across the gap after a frame
  task automatic watch();
    nv = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (wr_valid === 1'b1) begin
        nv++;
        got = wr;
      end
    end
  endtask
  task automatic do_wr(input logic [14:0] wa, input logic [7:0] wd, input int n);
    u_host.frame({1'b0, wa, wd}, n);
    watch();
    check("commit count", (n == 24) ? 1 : 0, nv);
    check("line drive", 0, u_host.oe_n);
    if (n == 24) begin
      check("commit word", {wa, wd}, got);
      last = {wa, wd};
      mem[wa[4:0]] = wd;
    end
  endtask
  task automatic do_rd(input logic [14:0] ra);
    u_host.frame({1'b1, ra, 8'h00}, 24);
    watch();
    check("read commit", 0, nv);
    check("read data", mem[ra[4:0]], u_host.rd_q);
    check("line drive", four_wire ? 0 : 8, u_host.oe_n);
    check("word kept", last, wr);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #1000000;
    num_errors++;
    test_done();
  end
  ////////////////////////////////////////
  // Main sequence
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    do_wr(15'h7fff, 8'hff, 24);
    for (int k = 0; k < 10; k++) begin
      a = 15'($random(seed));
      d = 8'($random(seed));
      do_wr(a, d, 24);
    end
    $display("write test done");
    for (int k = 0; k < 8; k++) do_rd(15'($random(seed)));
    do_rd(15'h7fff);
    $display("three-wire read test done");
    @(posedge clk_sys);
    #1 four_wire = 1'b1;
    do_wr(15'h0005, 8'ha5, 24);
    for (int k = 0; k < 8; k++) do_rd(15'($random(seed)));
    do_rd(15'h0005);
    $display("four-wire read test done");
    do_wr(15'h0005, 8'h3c, 23);
    do_rd(15'h0005);
    $display("short frame test done");
    test_done();
  end
endmodule // tb_top
